//--- design/imul_defs.svh
// constants of the integer multiply unit: field positions, codes, widths, steps
`ifndef IMUL_DEFS_SVH
`define IMUL_DEFS_SVH

// ----------------------------------------------------------------------------
// instruction word layout
// ----------------------------------------------------------------------------
`define IMUL_INSTR_W        24
`define IMUL_OPC_MSB        23
`define IMUL_OPC_LSB        17
`define IMUL_OPC_CODE       7'h5C
`define IMUL_BASE_SIGN_BIT  16
`define IMUL_SRC_SIGN_BIT   15
`define IMUL_BASE_MSB       14
`define IMUL_BASE_LSB       11
`define IMUL_DST_MSB        10
`define IMUL_DST_LSB        7
`define IMUL_MODE_MSB       6
`define IMUL_MODE_LSB       4
`define IMUL_SRC_MSB        3
`define IMUL_SRC_LSB        0
`define IMUL_LIT_MSB        4
`define IMUL_LIT_LSB        0

// ----------------------------------------------------------------------------
// datapath widths, limits and reset values
// ----------------------------------------------------------------------------
`define IMUL_WORD_W         16
`define IMUL_REG_AW         4
`define IMUL_LIT_W          5
`define IMUL_DST_MAX        4'hC
`define IMUL_PTR_STEP       16'h0002
`define IMUL_WORD_RST       16'h0000
`define IMUL_ADDR_RST       4'h0

`endif

//--- design/imul_pkg.sv
// types of the integer multiply unit
package imul_pkg;

    // source addressing mode, as held in the mode field
    typedef enum logic [2:0] {
        MODE_DIRECT   = 3'h0,
        MODE_INDIRECT = 3'h1,
        MODE_POST_DEC = 3'h2,
        MODE_POST_INC = 3'h3,
        MODE_PRE_DEC  = 3'h4,
        MODE_PRE_INC  = 3'h5,
        MODE_LIT_LO   = 3'h6,
        MODE_LIT_HI   = 3'h7
    } src_mode_t;

    // operand signedness pair: {base signed, source signed}
    typedef enum logic [1:0] {
        unsigned_unsigned_multiply_op = 2'h0,
        unsigned_signed_multiply_op   = 2'h1,
        signed_unsigned_multiply_op   = 2'h2,
        signed_signed_multiply_op     = 2'h3
    } mul_kind_t;

endpackage : imul_pkg

//--- design/imul_operand_if.sv
// carrier between the multiply unit and its multiplier array
`timescale 1ns/1ns
interface imul_operand_if;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic        a_signed;
    logic        b_signed;
    logic [31:0] product;

    modport requester (output op_a, output op_b, output a_signed, output b_signed,
                       input product);
    modport array     (input op_a, input op_b, input a_signed, input b_signed,
                       output product);
endinterface : imul_operand_if

//--- design/imul_multiplier_array.sv
// 16x16 multiplier array with per-operand signedness
`timescale 1ns/1ns
module imul_multiplier_array
    import imul_pkg::*;
(
    imul_operand_if.array ops
);
    logic signed [16:0] ext_a;
    logic signed [16:0] ext_b;
    logic signed [33:0] full_prod;

    // a 17-bit extension lets one signed array serve every sign mix
    always_comb begin
        ext_a     = {ops.a_signed & ops.op_a[15], ops.op_a};
        ext_b     = {ops.b_signed & ops.op_b[15], ops.op_b};
        full_prod = ext_a * ext_b;
    end

    // the product of two 16-bit values always fits 32 bits
    assign ops.product = full_prod[31:0];
endmodule : imul_multiplier_array

//--- design/integer_multiply_unit.sv
// integer multiply unit: 16x16 multiply instructions of the core datapath
`timescale 1ns/1ns
`include "imul_defs.svh"

module integer_multiply_unit
    import imul_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    // instruction issue
    input  wire logic                      instr_valid,
    input  wire logic [`IMUL_INSTR_W-1:0]  instr,
    // working register read ports, answered in the same cycle
    output logic [`IMUL_REG_AW-1:0]        base_rd_addr,
    input  wire logic [`IMUL_WORD_W-1:0]   base_rd_data,
    output logic [`IMUL_REG_AW-1:0]        src_rd_addr,
    input  wire logic [`IMUL_WORD_W-1:0]   src_rd_data,
    // data memory read port, answered in the same cycle
    output logic                           mem_rd_en,
    output logic [`IMUL_WORD_W-1:0]        mem_rd_addr,
    input  wire logic [`IMUL_WORD_W-1:0]   mem_rd_data,
    // product write-back to a register pair
    output logic                           res_wr_en,
    output logic [`IMUL_REG_AW-1:0]        res_lo_addr,
    output logic [`IMUL_WORD_W-1:0]        res_lo_data,
    output logic [`IMUL_REG_AW-1:0]        res_hi_addr,
    output logic [`IMUL_WORD_W-1:0]        res_hi_data,
    // pointer update write-back
    output logic                           ptr_wr_en,
    output logic [`IMUL_REG_AW-1:0]        ptr_wr_addr,
    output logic [`IMUL_WORD_W-1:0]        ptr_wr_data,
    // completion
    output logic                           instr_done,
    output logic                           instr_illegal
);

    // ------------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------------
    logic [`IMUL_REG_AW-1:0]  base_operand_register;
    logic [`IMUL_REG_AW-1:0]  source_operand_register;
    logic [`IMUL_REG_AW-1:0]  dst_field;
    logic [`IMUL_LIT_W-1:0]   short_literal_operand;
    src_mode_t                src_mode;
    mul_kind_t                mul_kind;
    logic                     opc_match;
    logic                     lit_form;
    logic                     bad_encoding;
    logic                     exec_ok;

    // field extraction; the base field only ever names a register
    always_comb begin
        opc_match = (instr[`IMUL_OPC_MSB:`IMUL_OPC_LSB] == `IMUL_OPC_CODE);
        mul_kind  = mul_kind_t'({instr[`IMUL_BASE_SIGN_BIT], instr[`IMUL_SRC_SIGN_BIT]});
        base_operand_register   = instr[`IMUL_BASE_MSB:`IMUL_BASE_LSB];
        source_operand_register = instr[`IMUL_SRC_MSB:`IMUL_SRC_LSB];
        dst_field               = instr[`IMUL_DST_MSB:`IMUL_DST_LSB];
        short_literal_operand   = instr[`IMUL_LIT_MSB:`IMUL_LIT_LSB];
        src_mode                = src_mode_t'(instr[`IMUL_MODE_MSB:`IMUL_MODE_LSB]);
        lit_form                = (src_mode == MODE_LIT_LO) || (src_mode == MODE_LIT_HI);
    end

    // encodings this unit refuses: odd or out-of-range pair, signed-signed
    // kind (handled elsewhere), and a literal under a signed source kind
    always_comb begin
        // destination must be an even register up to twelve
        bad_encoding = dst_field[0] || (dst_field > `IMUL_DST_MAX);
        if (mul_kind == signed_signed_multiply_op) begin
            bad_encoding = 1'b1;
        end
        if (lit_form && (mul_kind == unsigned_signed_multiply_op)) begin
            bad_encoding = 1'b1;
        end
        exec_ok = instr_valid && opc_match && !bad_encoding;
    end

    // ------------------------------------------------------------------------
    // source operand fetch and pointer arithmetic
    // ------------------------------------------------------------------------
    logic [`IMUL_WORD_W-1:0]  ptr_dec;
    logic [`IMUL_WORD_W-1:0]  ptr_inc;
    logic [`IMUL_WORD_W-1:0]  eff_addr;
    logic [`IMUL_WORD_W-1:0]  new_ptr;
    logic                     ptr_update;
    logic                     use_mem;
    logic [`IMUL_WORD_W-1:0]  src_value;

    // the read ports are driven straight from the fields so the register file
    // answers within the issue cycle; the single-cycle timing depends on it
    assign base_rd_addr = base_operand_register;
    assign src_rd_addr  = source_operand_register;

    // effective address and pointer update per mode, word step
    always_comb begin
        ptr_dec    = src_rd_data - `IMUL_PTR_STEP;
        ptr_inc    = src_rd_data + `IMUL_PTR_STEP;
        eff_addr   = src_rd_data;
        new_ptr    = src_rd_data;
        ptr_update = 1'b0;
        use_mem    = 1'b1;
        unique case (src_mode)
            MODE_DIRECT: begin
                use_mem = 1'b0;
            end
            MODE_INDIRECT: begin
                ptr_update = 1'b0;
            end
            MODE_POST_DEC: begin
                new_ptr    = ptr_dec;
                ptr_update = 1'b1;
            end
            MODE_POST_INC: begin
                new_ptr    = ptr_inc;
                ptr_update = 1'b1;
            end
            MODE_PRE_DEC: begin
                eff_addr   = ptr_dec;
                new_ptr    = ptr_dec;
                ptr_update = 1'b1;
            end
            MODE_PRE_INC: begin
                eff_addr   = ptr_inc;
                new_ptr    = ptr_inc;
                ptr_update = 1'b1;
            end
            MODE_LIT_LO, MODE_LIT_HI: begin
                use_mem = 1'b0;
            end
        endcase
    end

    // memory is only strobed for an instruction that will execute, so a
    // refused word never causes a side-effecting read
    assign mem_rd_en   = exec_ok && use_mem;
    assign mem_rd_addr = eff_addr;

    // short literal, direct register value or memory word through the pointer
    always_comb begin
        if (lit_form) begin
            src_value = {{(`IMUL_WORD_W-`IMUL_LIT_W){1'b0}}, short_literal_operand};
        end else if (use_mem) begin
            src_value = mem_rd_data;
        end else begin
            src_value = src_rd_data;
        end
    end

    // ------------------------------------------------------------------------
    // multiplier array
    // ------------------------------------------------------------------------
    imul_operand_if mul_ops ();

    // sign flags clear for the unsigned-unsigned kind
    always_comb begin
        mul_ops.op_a     = base_rd_data;
        mul_ops.op_b     = src_value;
        mul_ops.a_signed = (mul_kind == signed_unsigned_multiply_op);
        mul_ops.b_signed = (mul_kind == unsigned_signed_multiply_op) && !lit_form;
    end

    imul_multiplier_array u_array (
        .ops (mul_ops.array)
    );

    // ------------------------------------------------------------------------
    // write-back registers
    // ------------------------------------------------------------------------
    logic                     res_wr_en_q,   res_wr_en_d;
    logic [`IMUL_REG_AW-1:0]  res_lo_addr_q, res_lo_addr_d;
    logic [`IMUL_REG_AW-1:0]  res_hi_addr_q, res_hi_addr_d;
    logic [`IMUL_WORD_W-1:0]  res_lo_data_q, res_lo_data_d;
    logic [`IMUL_WORD_W-1:0]  res_hi_data_q, res_hi_data_d;
    logic                     ptr_wr_en_q,   ptr_wr_en_d;
    logic [`IMUL_REG_AW-1:0]  ptr_wr_addr_q, ptr_wr_addr_d;
    logic [`IMUL_WORD_W-1:0]  ptr_wr_data_q, ptr_wr_data_d;
    logic                     done_q,        done_d;
    logic                     illegal_q,     illegal_d;

    // next write-back; data words hold their last value when idle so the
    // register file sees no toggling on quiet cycles
    always_comb begin
        res_lo_addr_d = res_lo_addr_q;
        res_hi_addr_d = res_hi_addr_q;
        res_lo_data_d = res_lo_data_q;
        res_hi_data_d = res_hi_data_q;
        ptr_wr_addr_d = ptr_wr_addr_q;
        ptr_wr_data_d = ptr_wr_data_q;
        // one issue cycle, result presented on the next edge
        res_wr_en_d   = exec_ok;
        ptr_wr_en_d   = exec_ok && ptr_update;
        done_d        = exec_ok;
        illegal_d     = instr_valid && !exec_ok;
        if (exec_ok) begin
            // low word to even register, high word to the next
            res_lo_addr_d = dst_field;
            res_hi_addr_d = dst_field + `IMUL_REG_AW'(1);
            res_lo_data_d = mul_ops.product[`IMUL_WORD_W-1:0];
            res_hi_data_d = mul_ops.product[2*`IMUL_WORD_W-1:`IMUL_WORD_W];
        end
        if (exec_ok && ptr_update) begin
            // the update always lands on the source register
            ptr_wr_addr_d = source_operand_register;
            ptr_wr_data_d = new_ptr;
        end
    end

    // write-back registers; no status flag port exists, so flags stay put
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            res_wr_en_q   <= 1'b0;
            res_lo_addr_q <= `IMUL_ADDR_RST;
            res_hi_addr_q <= `IMUL_ADDR_RST;
            res_lo_data_q <= `IMUL_WORD_RST;
            res_hi_data_q <= `IMUL_WORD_RST;
            ptr_wr_en_q   <= 1'b0;
            ptr_wr_addr_q <= `IMUL_ADDR_RST;
            ptr_wr_data_q <= `IMUL_WORD_RST;
            done_q        <= 1'b0;
            illegal_q     <= 1'b0;
        end else begin
            res_wr_en_q   <= res_wr_en_d;
            res_lo_addr_q <= res_lo_addr_d;
            res_hi_addr_q <= res_hi_addr_d;
            res_lo_data_q <= res_lo_data_d;
            res_hi_data_q <= res_hi_data_d;
            ptr_wr_en_q   <= ptr_wr_en_d;
            ptr_wr_addr_q <= ptr_wr_addr_d;
            ptr_wr_data_q <= ptr_wr_data_d;
            done_q        <= done_d;
            illegal_q     <= illegal_d;
        end
    end

    // outputs straight from flip-flops
    assign res_wr_en     = res_wr_en_q;
    assign res_lo_addr   = res_lo_addr_q;
    assign res_hi_addr   = res_hi_addr_q;
    assign res_lo_data   = res_lo_data_q;
    assign res_hi_data   = res_hi_data_q;
    assign ptr_wr_en     = ptr_wr_en_q;
    assign ptr_wr_addr   = ptr_wr_addr_q;
    assign ptr_wr_data   = ptr_wr_data_q;
    assign instr_done    = done_q;
    assign instr_illegal = illegal_q;

endmodule : integer_multiply_unit

//--- tb/imul_asserts.sv
// concurrent checks on the ports of the integer multiply unit
`timescale 1ns/1ns
module imul_checker
    import imul_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        instr_valid,
    input wire logic [23:0] instr,
    input wire logic [3:0]  base_rd_addr,
    input wire logic [15:0] base_rd_data,
    input wire logic [3:0]  src_rd_addr,
    input wire logic [15:0] src_rd_data,
    input wire logic        mem_rd_en,
    input wire logic [15:0] mem_rd_addr,
    input wire logic        res_wr_en,
    input wire logic [3:0]  res_lo_addr,
    input wire logic [15:0] res_lo_data,
    input wire logic [3:0]  res_hi_addr,
    input wire logic [15:0] res_hi_data,
    input wire logic        ptr_wr_en,
    input wire logic [15:0] ptr_wr_data,
    input wire logic        instr_done,
    input wire logic        instr_illegal
);
    // ------------------------------------------------------------
    // decode of the issued word, kept apart from the unit's own
    // ------------------------------------------------------------
    logic [2:0]  mode;
    logic        lit;
    logic        legal;
    logic [31:0] prod;
    // the refusal list is spelled out here so a slip in it shows up
    always_comb begin
        mode  = instr[6:4];
        lit   = mode[2] & mode[1];
        legal = instr[23:17] == 7'h5C && !instr[7] && instr[10:7] <= 4'hC
                && instr[16:15] != 2'h3 && !(lit && instr[16:15] == 2'h1);
    end
    assign prod = {res_hi_data, res_lo_data};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    one_cycle_a: assert property (instr_valid && legal |=> res_wr_en && instr_done)
        else $error("legal word not answered one cycle later");
    refuse_word_a: assert property (instr_valid && !legal |=> instr_illegal && !res_wr_en)
        else $error("refused word still wrote back");
    pair_addr_a: assert property (res_wr_en
        |-> res_hi_addr == res_lo_addr + 4'h1 && !res_lo_addr[0])
        else $error("product pair not even then next");
    base_sel_a: assert property (instr_valid |-> base_rd_addr == instr[14:11])
        else $error("base read address not from base field");
    src_sel_a: assert property (instr_valid |-> src_rd_addr == instr[3:0])
        else $error("source read address not from source field");
    mem_fetch_a: assert property (instr_valid
        |-> mem_rd_en == (legal && mode != 3'h0 && !lit))
        else $error("memory fetch not matching the mode");
    uu_prod_a: assert property (instr_valid && legal && instr[16:15] == 2'h0 && mode == 3'h0
        |=> prod == $past(base_rd_data) * $past(src_rd_data))
        else $error("unsigned product wrong");
    lit_prod_a: assert property (instr_valid && legal && instr[16:15] == 2'h0 && lit
        |=> prod == $past(base_rd_data) * $past({11'h000, instr[4:0]}))
        else $error("literal product wrong");
    post_inc_a: assert property (instr_valid && legal && mode == 3'h3
        |=> ptr_wr_en && ptr_wr_data == $past(src_rd_data) + 16'h0002)
        else $error("post increment pointer wrong");
    pre_dec_a: assert property (instr_valid && legal && mode == 3'h4
        |-> mem_rd_addr == src_rd_data - 16'h0002)
        else $error("pre decrement address wrong");
    // main scenarios reached
    lit_c: cover property (instr_valid && legal && lit);
    refuse_c: cover property (instr_valid && !legal);
    ptr_c: cover property (res_wr_en && ptr_wr_en);
endmodule : imul_checker

bind integer_multiply_unit imul_checker u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr(instr), .base_rd_addr(base_rd_addr),
    .base_rd_data(base_rd_data), .src_rd_addr(src_rd_addr), .src_rd_data(src_rd_data),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .res_wr_en(res_wr_en),
    .res_lo_addr(res_lo_addr), .res_lo_data(res_lo_data), .res_hi_addr(res_hi_addr),
    .res_hi_data(res_hi_data), .ptr_wr_en(ptr_wr_en), .ptr_wr_data(ptr_wr_data),
    .instr_done(instr_done), .instr_illegal(instr_illegal));

//--- tb/imul_regfile_model.sv
// behavioural working register file and data memory facing the unit
`timescale 1ns/1ns
module imul_regfile_model (
    input  wire logic        sys_clk,
    input  wire logic [3:0]  base_rd_addr,
    output logic      [15:0] base_rd_data,
    input  wire logic [3:0]  src_rd_addr,
    output logic      [15:0] src_rd_data,
    input  wire logic        mem_rd_en,
    input  wire logic [15:0] mem_rd_addr,
    output logic      [15:0] mem_rd_data,
    input  wire logic        res_wr_en,
    input  wire logic [3:0]  res_lo_addr,
    input  wire logic [15:0] res_lo_data,
    input  wire logic [3:0]  res_hi_addr,
    input  wire logic [15:0] res_hi_data,
    input  wire logic        ptr_wr_en,
    input  wire logic [3:0]  ptr_wr_addr,
    input  wire logic [15:0] ptr_wr_data
);
    logic [15:0] rf [16];
    logic [15:0] mem [256];
    logic [15:0] junk_q = 16'hA5A5;
    // same-cycle answers; an unselected memory shows a moving pattern, never old data
    assign base_rd_data = rf[base_rd_addr];
    assign src_rd_data = rf[src_rd_addr];
    assign mem_rd_data = mem_rd_en ? mem[mem_rd_addr[8:1]] : junk_q;
    // write-back; the pointer write lands last so it wins a clash
    always @(posedge sys_clk) begin
        junk_q <= junk_q + 16'h3C5B;
        if (res_wr_en) begin
            rf[res_lo_addr] <= res_lo_data;
            rf[res_hi_addr] <= res_hi_data;
        end
        if (ptr_wr_en)
            rf[ptr_wr_addr] <= ptr_wr_data;
    end
endmodule : imul_regfile_model

//--- tb/integer_multiply_unit_tb.sv
// self-checking bench of the integer multiply unit
`timescale 1ns/1ns
module integer_multiply_unit_tb;
    import imul_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [23:0] instr = 24'h000000;
    logic [3:0]  base_rd_addr, src_rd_addr, res_lo_addr, res_hi_addr, ptr_wr_addr;
    logic [15:0] base_rd_data, src_rd_data, mem_rd_addr, mem_rd_data;
    logic [15:0] res_lo_data, res_hi_data, ptr_wr_data;
    logic        mem_rd_en, res_wr_en, ptr_wr_en, instr_done, instr_illegal;
    logic        done_s, ill_s;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;

    always #4 sys_clk = ~sys_clk;

    integer_multiply_unit DUT (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr(instr), .base_rd_addr(base_rd_addr), .base_rd_data(base_rd_data),
        .src_rd_addr(src_rd_addr), .src_rd_data(src_rd_data), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .res_wr_en(res_wr_en),
        .res_lo_addr(res_lo_addr), .res_lo_data(res_lo_data), .res_hi_addr(res_hi_addr),
        .res_hi_data(res_hi_data), .ptr_wr_en(ptr_wr_en), .ptr_wr_addr(ptr_wr_addr),
        .ptr_wr_data(ptr_wr_data), .instr_done(instr_done), .instr_illegal(instr_illegal));

    imul_regfile_model pm (.sys_clk(sys_clk), .base_rd_addr(base_rd_addr),
        .base_rd_data(base_rd_data), .src_rd_addr(src_rd_addr), .src_rd_data(src_rd_data),
        .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .res_wr_en(res_wr_en), .res_lo_addr(res_lo_addr), .res_lo_data(res_lo_data),
        .res_hi_addr(res_hi_addr), .res_hi_data(res_hi_data), .ptr_wr_en(ptr_wr_en),
        .ptr_wr_addr(ptr_wr_addr), .ptr_wr_data(ptr_wr_data));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [23:0] enc(logic [1:0] k, logic [3:0] b, logic [3:0] d,
                                        logic [2:0] m, logic [3:0] s);
        return {7'h5C, k, b, d, m, s};
    endfunction : enc

    // valid stays up between calls, so words issue back to back
    task automatic run(logic [23:0] w);
        instr = w;
        instr_valid = 1'b1;
        @(negedge sys_clk);
        done_s = instr_done;
        ill_s = instr_illegal;
    endtask : run

    task automatic idle;
        instr_valid = 1'b0;
        @(negedge sys_clk);
    endtask : idle

    function automatic logic [31:0] pair(logic [3:0] d);
        return {pm.rf[d + 4'h1], pm.rf[d]};
    endfunction : pair

    task automatic close_out;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_direct;
        pm.rf[0] = 16'hFFFF;
        pm.rf[1] = 16'hFFFF;
        pm.rf[4] = 16'h8000;
        pm.rf[5] = 16'hFFFF;
        run(enc(unsigned_unsigned_multiply_op, 4'h0, 4'h2, 3'h0, 4'h1));
        run(enc(signed_unsigned_multiply_op, 4'h4, 4'h6, 3'h0, 4'h5));
        run(enc(unsigned_signed_multiply_op, 4'h4, 4'hC, 3'h0, 4'h5));
        idle;
        chk("uu direct", pair(4'h2), 32'hFFFE0001);
        chk("su direct", pair(4'h6), 32'h80008000);
        chk("us top pair", pair(4'hC), 32'hFFFF8000);
    endtask : t_direct

    task automatic t_modes;
        logic [15:0] a;
        logic [15:0] np;
        logic [15:0] val;
        for (int m = 1; m <= 5; m++) begin
            pm.rf[9] = 16'h0040;
            pm.rf[8] = 16'h0003;
            pm.mem[8'h1F] = 16'h1111;
            pm.mem[8'h20] = 16'h2222;
            pm.mem[8'h21] = 16'h3333;
            a = (m == 4) ? 16'h003E : ((m == 5) ? 16'h0042 : 16'h0040);
            np = (m == 1) ? 16'h0040 : (m[0] ? 16'h0042 : 16'h003E);
            val = 16'h1111 * ((a - 16'h003C) >> 1);
            run(enc(2'h0, 4'h8, 4'hA, m[2:0], 4'h9));
            chk("done", {31'h0, done_s}, 32'h1);
            idle;
            chk("mode product", pair(4'hA), 32'h3 * val);
            chk("pointer", {16'h0, pm.rf[9]}, {16'h0, np});
        end
    endtask : t_modes

    task automatic t_literal;
        pm.rf[7] = 16'hF240;
        run(enc(2'h0, 4'h7, 4'h0, 3'h7, 4'hF));
        run(enc(2'h0, 4'h7, 4'h4, 3'h6, 4'h0));
        run(enc(signed_unsigned_multiply_op, 4'h7, 4'h2, 3'h7, 4'h0));
        idle;
        chk("lit 31", pair(4'h0), 32'hF240 * 32'h1F);
        chk("lit 0", pair(4'h4), 32'h0);
        chk("su lit", pair(4'h2), 32'hFFFF2400);
    endtask : t_literal

    task automatic t_refused;
        logic [23:0] w [5];
        w = '{{7'h5D, 17'h00119}, enc(2'h0, 4'h0, 4'h3, 3'h3, 4'h9),
              enc(2'h0, 4'h0, 4'hE, 3'h3, 4'h9), enc(2'h3, 4'h0, 4'h2, 3'h3, 4'h9),
              enc(2'h1, 4'h0, 4'h2, 3'h6, 4'h9)};
        for (int i = 0; i < 16; i++)
            pm.rf[i] = 16'hBEEF;
        for (int i = 0; i < 5; i++) begin
            run(w[i]);
            chk("refused", {30'h0, ill_s, done_s}, 32'h2);
        end
        idle;
        for (int i = 0; i < 16; i++)
            chk("untouched", {16'h0, pm.rf[i]}, 32'hBEEF);
    endtask : t_refused

    // reset in mid-run: pending write-back is dropped, first word after release runs
    task automatic t_reset;
        pm.rf[2] = 16'h1234;
        pm.rf[3] = 16'h0100;
        run(enc(2'h0, 4'h2, 4'h8, 3'h0, 4'h3));
        instr_valid = 1'b0;
        rstn = 1'b0;
        #1;
        chk("reset regs", {ptr_wr_data, res_lo_addr, res_hi_addr, ptr_wr_addr,
            res_wr_en, ptr_wr_en, instr_done, instr_illegal}, 32'h0);
        chk("reset data", {res_hi_data, res_lo_data}, 32'h0);
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        run(enc(2'h0, 4'h2, 4'h8, 3'h0, 4'h3));
        chk("done after reset", {31'h0, done_s}, 32'h1);
        idle;
        chk("product after reset", pair(4'h8), 32'h00123400);
    endtask : t_reset

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            close_out;
        end
    end

    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        t_direct;
        t_modes;
        t_literal;
        t_refused;
        t_reset;
        close_out;
    end
endmodule : integer_multiply_unit_tb
